/* File: hw/cal_clock_core.v */
// Buffered calendar clock core with byte-wide host port, supervisor and event outputs
`timescale 1ns/1ps
`include "cal_clock_regs.vh"

module cal_clock_core #(
	parameter SEC_CYCLES = `SEC_CYCLES,
	parameter REC_CYCLES = `REC_CYCLES
) (
	input wire ref_clk,
	input wire arst_n,
	input wire osc_run,
	input wire supply_fail,
	input wire chip_sel_n,
	input wire out_en_n,
	input wire wr_en_n,
	input wire [4:0] address_lines,
	input wire [7:0] data_in,
	output reg [7:0] data_out,
	output wire data_oe_n,
	input wire wake_input_n,
	output wire irq_n,
	output wire rst_n,
	output wire power_on_request_n
);

	// Days in a month; years 00..99, every fourth one leap
	function [4:0] month_days;
		input [3:0] m;
		input [6:0] y;
		begin
			case (m)
				4'h4, 4'h6, 4'h9, 4'hB: month_days = 5'h1E;
				4'h2: month_days = (y[1:0] == 2'h0) ? 5'h1D : 5'h1C;
				default: month_days = 5'h1F;
			endcase
		end
	endfunction

	// Internal counting set
	reg [5:0] sec_ff, min_ff;
	reg [4:0] hour_ff, date_ff;
	reg [2:0] dow_ff;
	reg [3:0] mon_ff;
	reg [6:0] year_ff;
	reg [5:0] nxt_sec, nxt_min;
	reg [4:0] nxt_hour, nxt_date;
	reg [2:0] nxt_dow;
	reg [3:0] nxt_mon;
	reg [6:0] nxt_year;
	// External, host-visible set
	reg [5:0] xsec_ff, xmin_ff;
	reg [4:0] xhour_ff, xdate_ff;
	reg [2:0] xdow_ff;
	reg [3:0] xmon_ff;
	reg [6:0] xyear_ff;
	// Alarm, watchdog, control, flags
	reg [7:0] alm_sec_ff, alm_min_ff, alm_hour_ff, alm_date_ff;
	reg [7:0] wd_load_ff, wd_cnt_ff;
	reg [7:0] ctrl_ff;
	reg [2:0] flag_ff; // Alarm, watchdog, wake
	reg pwr_ff; // Power request active
	reg dirty_ff; // Host wrote a time register while frozen
	// Timebase and supervisor
	reg [31:0] pre_ff;
	reg tick_d_ff; // One cycle after an internal update
	reg [31:0] rec_ff; // Reset recovery countdown
	reg wr_d_ff; // Write strobe seen last cycle
	reg wake_d_ff; // Wake input last cycle
	reg irq_ff, rst_ff, pwr_out_ff;

	// Port decode; supply fail forces deselect
	wire sel = !chip_sel_n && !supply_fail;
	wire wr_act = sel && !wr_en_n;
	wire wr_go = wr_act && !wr_d_ff; // Later of the two falling edges
	wire rd_act = sel && !out_en_n && wr_en_n;
	wire tick = osc_run && (pre_ff == SEC_CYCLES - 1);
	wire te = ctrl_ff[`CTL_TE];
	// TE 0 to 1 loads host values only after a time write, so a read freeze loses no time
	wire te_rise = wr_go && (address_lines == `OFF_CTRL) && data_in[`CTL_TE] && !te && dirty_ff;
	wire wr_time = wr_go && (address_lines <= `OFF_YEAR);
	wire wake_ev = wake_d_ff && !wake_input_n;
	wire wd_ev = tick_d_ff && (wd_cnt_ff == 8'h01);
	wire alm_ev = tick_d_ff && (alm_sec_ff[`ALM_MASK] || alm_sec_ff[5:0] == sec_ff)
		&& (alm_min_ff[`ALM_MASK] || alm_min_ff[5:0] == min_ff)
		&& (alm_hour_ff[`ALM_MASK] || alm_hour_ff[4:0] == hour_ff)
		&& (alm_date_ff[`ALM_MASK] || alm_date_ff[4:0] == date_ff);

	// Read data is registered; driven only during a read
	assign data_oe_n = !rd_act;
	assign irq_n = !irq_ff;
	assign rst_n = !rst_ff;
	assign power_on_request_n = !pwr_out_ff;

	// One-second prescaler; stops with the oscillator
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			pre_ff <= 32'h00000000;
			tick_d_ff <= 1'b0;
		end else begin
			tick_d_ff <= tick;
			if (!osc_run || tick) begin
				pre_ff <= 32'h00000000;
			end else begin
				pre_ff <= pre_ff + 32'h00000001;
			end
		end
	end

	// Next internal time: load from host set, else ripple on a tick
	always @* begin
		nxt_sec = sec_ff;
		nxt_min = min_ff;
		nxt_hour = hour_ff;
		nxt_dow = dow_ff;
		nxt_date = date_ff;
		nxt_mon = mon_ff;
		nxt_year = year_ff;
		if (te_rise) begin
			// Host-set time becomes the running time
			nxt_sec = xsec_ff;
			nxt_min = xmin_ff;
			nxt_hour = xhour_ff;
			nxt_dow = xdow_ff;
			nxt_date = xdate_ff;
			nxt_mon = xmon_ff;
			nxt_year = xyear_ff;
		end else if (tick) begin
			if (sec_ff != 6'h3B) begin
				nxt_sec = sec_ff + 6'h01;
			end else begin
				nxt_sec = 6'h00;
				if (min_ff != 6'h3B) begin
					nxt_min = min_ff + 6'h01;
				end else begin
					nxt_min = 6'h00;
					if (hour_ff != 5'h17) begin
						nxt_hour = hour_ff + 5'h01;
					end else begin
						// Midnight: day of week and date roll
						nxt_hour = 5'h00;
						nxt_dow = (dow_ff == 3'h7) ? `DOW_RST : dow_ff + 3'h1;
						if (date_ff < month_days(mon_ff, year_ff)) begin
							nxt_date = date_ff + 5'h01;
						end else begin
							nxt_date = `DATE_RST;
							if (mon_ff != 4'hC) begin
								nxt_mon = mon_ff + 4'h1;
							end else begin
								nxt_mon = `MONTH_RST;
								nxt_year = (year_ff == 7'h63) ? 7'h00 : year_ff + 7'h01;
							end
						end
					end
				end
			end
		end
	end

	// Internal set keeps running while the host side is frozen
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			sec_ff <= 6'h00;
			min_ff <= 6'h00;
			hour_ff <= 5'h00;
			dow_ff <= `DOW_RST;
			date_ff <= `DATE_RST;
			mon_ff <= `MONTH_RST;
			year_ff <= 7'h00;
		end else begin
			sec_ff <= nxt_sec;
			min_ff <= nxt_min;
			hour_ff <= nxt_hour;
			dow_ff <= nxt_dow;
			date_ff <= nxt_date;
			mon_ff <= nxt_mon;
			year_ff <= nxt_year;
		end
	end

	// External set: host writes, or a copy the cycle after each tick while TE is set
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			xsec_ff <= 6'h00;
			xmin_ff <= 6'h00;
			xhour_ff <= 5'h00;
			xdow_ff <= `DOW_RST;
			xdate_ff <= `DATE_RST;
			xmon_ff <= `MONTH_RST;
			xyear_ff <= 7'h00;
		end else if (wr_time) begin
			// Host write wins over a copy in the same cycle
			case (address_lines)
				`OFF_SEC: xsec_ff <= data_in[5:0];
				`OFF_MIN: xmin_ff <= data_in[5:0];
				`OFF_HOUR: xhour_ff <= data_in[4:0];
				`OFF_DOW: xdow_ff <= data_in[2:0];
				`OFF_DATE: xdate_ff <= data_in[4:0];
				`OFF_MONTH: xmon_ff <= data_in[3:0];
				default: xyear_ff <= data_in[6:0];
			endcase
		end else if (tick_d_ff && te) begin
			xsec_ff <= sec_ff;
			xmin_ff <= min_ff;
			xhour_ff <= hour_ff;
			xdow_ff <= dow_ff;
			xdate_ff <= date_ff;
			xmon_ff <= mon_ff;
			xyear_ff <= year_ff;
		end
	end

	// Alarm, watchdog and control registers
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			alm_sec_ff <= `ALM_RST;
			alm_min_ff <= `ALM_RST;
			alm_hour_ff <= `ALM_RST;
			alm_date_ff <= `ALM_RST;
			wd_load_ff <= 8'h00;
			wd_cnt_ff <= 8'h00;
			ctrl_ff <= `CTRL_RST;
		end else begin
			// Watchdog counts seconds; zero load disables it
			if (wr_go && address_lines == `OFF_WDOG) begin
				wd_load_ff <= data_in;
				wd_cnt_ff <= data_in;
			end else if (wd_ev) begin
				wd_cnt_ff <= wd_load_ff;
			end else if (tick_d_ff && wd_cnt_ff != 8'h00) begin
				wd_cnt_ff <= wd_cnt_ff - 8'h01;
			end
			if (wr_go) begin
				case (address_lines)
					`OFF_ALM_SEC: alm_sec_ff <= data_in;
					`OFF_ALM_MIN: alm_min_ff <= data_in;
					`OFF_ALM_HOUR: alm_hour_ff <= data_in;
					`OFF_ALM_DATE: alm_date_ff <= data_in;
					`OFF_CTRL: ctrl_ff <= data_in;
					default: ctrl_ff <= ctrl_ff;
				endcase
			end
		end
	end

	// Sticky event flags and power request; a new event beats the clear
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			flag_ff <= 3'h0;
			pwr_ff <= 1'b0;
			wr_d_ff <= 1'b0;
			wake_d_ff <= 1'b1;
			dirty_ff <= 1'b0;
		end else begin
			wr_d_ff <= wr_act;
			wake_d_ff <= wake_input_n;
			dirty_ff <= !te && (dirty_ff || wr_time);
			if (wr_go && address_lines == `OFF_FLAGS) begin
				flag_ff <= (flag_ff & ~data_in[2:0]) | {wake_ev, wd_ev, alm_ev};
			end else begin
				flag_ff <= flag_ff | {wake_ev, wd_ev, alm_ev};
			end
			// Wake events assert the request even while the port is blocked
			if ((alm_ev && ctrl_ff[`CTL_ALARM_PWR]) || (wake_ev && ctrl_ff[`CTL_WAKE_PWR])) begin
				pwr_ff <= 1'b1;
			end else if (wr_go && address_lines == `OFF_FLAGS && data_in[`FLG_PWR_REL]) begin
				pwr_ff <= 1'b0;
			end
		end
	end

	// Supervisor: reset held in fail and for the recovery time after
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rec_ff <= REC_CYCLES; // Power-on counts as a recovery
		end else if (supply_fail || (wd_ev && ctrl_ff[`CTL_WDOG_RST])) begin
			rec_ff <= REC_CYCLES;
		end else if (rec_ff != 32'h00000000) begin
			rec_ff <= rec_ff - 32'h00000001;
		end
	end

	// Registered pin levels; interrupt routes enabled flags, the watchdog flag only while CTL_WDOG_RST is clear
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_ff <= 1'b0;
			rst_ff <= 1'b1;
			pwr_out_ff <= 1'b0;
		end else begin
			irq_ff <= (flag_ff[`FLG_ALARM] && ctrl_ff[`CTL_ALARM_IE])
				|| (flag_ff[`FLG_WDOG] && ctrl_ff[`CTL_WDOG_IE] && !ctrl_ff[`CTL_WDOG_RST])
				|| (flag_ff[`FLG_WAKE] && ctrl_ff[`CTL_WAKE_IE]);
			rst_ff <= supply_fail || (rec_ff != 32'h00000000);
			pwr_out_ff <= pwr_ff;
		end
	end

	// Read mux into the output register
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			data_out <= 8'h00;
		end else begin
			case (address_lines)
				`OFF_SEC: data_out <= {2'h0, xsec_ff};
				`OFF_MIN: data_out <= {2'h0, xmin_ff};
				`OFF_HOUR: data_out <= {3'h0, xhour_ff};
				`OFF_DOW: data_out <= {5'h00, xdow_ff};
				`OFF_DATE: data_out <= {3'h0, xdate_ff};
				`OFF_MONTH: data_out <= {4'h0, xmon_ff};
				`OFF_YEAR: data_out <= {1'b0, xyear_ff};
				`OFF_ALM_SEC: data_out <= alm_sec_ff;
				`OFF_ALM_MIN: data_out <= alm_min_ff;
				`OFF_ALM_HOUR: data_out <= alm_hour_ff;
				`OFF_ALM_DATE: data_out <= alm_date_ff;
				`OFF_WDOG: data_out <= wd_cnt_ff;
				`OFF_FLAGS: data_out <= {pwr_ff, 4'h0, flag_ff};
				`OFF_CTRL: data_out <= ctrl_ff;
				default: data_out <= 8'h00;
			endcase
		end
	end

endmodule

/* File: hw/cal_clock_regs.vh */
// Register offsets, field positions, reset values and timing constants of the calendar clock
`ifndef CAL_CLOCK_REGS_VH
`define CAL_CLOCK_REGS_VH

// Host-visible register offsets on address_lines
`define OFF_SEC 5'h00
`define OFF_MIN 5'h01
`define OFF_HOUR 5'h02
`define OFF_DOW 5'h03
`define OFF_DATE 5'h04
`define OFF_MONTH 5'h05
`define OFF_YEAR 5'h06
`define OFF_ALM_SEC 5'h08
`define OFF_ALM_MIN 5'h09
`define OFF_ALM_HOUR 5'h0A
`define OFF_ALM_DATE 5'h0B
`define OFF_WDOG 5'h0C
`define OFF_FLAGS 5'h0D
`define OFF_CTRL 5'h0E

// Flag register bit positions (write 1 to clear)
`define FLG_ALARM 0
`define FLG_WDOG 1
`define FLG_WAKE 2
`define FLG_PWR_REL 7

// Control register bit positions
`define CTL_ALARM_IE 0
`define CTL_WDOG_IE 1
`define CTL_WAKE_IE 2
`define CTL_WDOG_RST 3
`define CTL_ALARM_PWR 4
`define CTL_WAKE_PWR 5
`define CTL_TE 7

// Alarm byte: bit 7 set means field ignored
`define ALM_MASK 7

// Reset values
`define CTRL_RST 8'h80
`define ALM_RST 8'h80
`define DATE_RST 5'h01
`define MONTH_RST 4'h1
`define DOW_RST 3'h1

// Timing
`define CLK_HZ 100000000
`define REC_MS 200
`define SEC_CYCLES (`CLK_HZ)
`define REC_CYCLES (`REC_MS * (`CLK_HZ / 1000))

`endif

/* File: test/cal_clock_checker.sv */
// Port checker for the calendar clock core
`timescale 1ns/1ps
module cal_clock_checker #(
	parameter SEC_CYCLES = 20,
	parameter REC_CYCLES = 10
) (
	input wire ref_clk,
	input wire arst_n,
	input wire osc_run,
	input wire supply_fail,
	input wire chip_sel_n,
	input wire out_en_n,
	input wire wr_en_n,
	input wire [4:0] address_lines,
	input wire [7:0] data_in,
	input wire [7:0] data_out,
	input wire data_oe_n,
	input wire wake_input_n,
	input wire irq_n,
	input wire rst_n,
	input wire power_on_request_n
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	// Read decode as the host sees it
	wire rd = !chip_sel_n && !out_en_n && wr_en_n && !supply_fail;
	oe_read_a: assert property (data_oe_n == !rd)
		else $error("data enable differs from read decode");
	fail_hiz_a: assert property (supply_fail |-> data_oe_n)
		else $error("data driven during supply fail");
	fail_reset_a: assert property (supply_fail |=> !rst_n)
		else $error("reset out not held in supply fail");
	recovery_a: assert property ($fell(supply_fail) |-> !rst_n [*8])
		else $error("reset out released too early");
	rst_rise_a: assert property ($rose(rst_n) |-> !$past(supply_fail, 8))
		else $error("reset out rose without recovery");
	pwr_release_a: assert property ((!chip_sel_n && !wr_en_n && !supply_fail
		&& address_lines == 5'h0D && data_in[7] && wake_input_n && $past(wake_input_n))
		|-> ##[1:3] power_on_request_n) else $error("power request not released");
	reserved_zero_a: assert property ((rd && address_lines == 5'h07) |=> data_out == 8'h00)
		else $error("reserved address read not zero");
	sec_range_a: assert property ((rd && address_lines == 5'h00) |=> data_out < 8'h3C)
		else $error("seconds out of range");
endmodule

bind cal_clock_core cal_clock_checker #(.SEC_CYCLES(SEC_CYCLES), .REC_CYCLES(REC_CYCLES))
	i_cal_clock_checker (.ref_clk, .arst_n, .osc_run, .supply_fail, .chip_sel_n, .out_en_n,
	.wr_en_n, .address_lines, .data_in, .data_out, .data_oe_n, .wake_input_n, .irq_n, .rst_n,
	.power_on_request_n);

/* File: test/host_bus_model.sv */
// Host processor model on the byte-wide port
`timescale 1ns/1ps
module host_bus_model (
	input wire ref_clk,
	output logic chip_sel_n,
	output logic out_en_n,
	output logic wr_en_n,
	output logic [4:0] address_lines,
	output logic [7:0] data_in,
	input wire [7:0] data_out
);
	// Idle bus from time zero
	initial begin
		chip_sel_n = 1'b1;
		out_en_n = 1'b1;
		wr_en_n = 1'b1;
		address_lines = 5'h1F;
		data_in = 8'h00;
	end
	// Byte write; address held through the whole cycle
	task wr(input logic [4:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		address_lines = a;
		data_in = d;
		chip_sel_n = 1'b0;
		wr_en_n = 1'b0;
		@(negedge ref_clk);
		chip_sel_n = 1'b1;
		wr_en_n = 1'b1;
		data_in = ~d; // Released lines stop showing data
		@(negedge ref_clk); // Inactive gap before next access
	endtask
	// Byte read; data taken two falling edges after address settles
	task rd(input logic [4:0] a, output logic [7:0] d);
		@(negedge ref_clk);
		address_lines = a;
		chip_sel_n = 1'b0;
		out_en_n = 1'b0;
		repeat (2) @(negedge ref_clk);
		d = data_out;
		chip_sel_n = 1'b1;
		out_en_n = 1'b1;
	endtask
endmodule

/* File: test/test_cal_clock_core.sv */
// Self-checking bench for the calendar clock core
`timescale 1ns/1ps
module test_cal_clock_core;
	logic ref_clk, arst_n, osc_run, supply_fail, wake_input_n;
	wire chip_sel_n, out_en_n, wr_en_n, data_oe_n, irq_n, rst_n, power_on_request_n;
	wire [4:0] address_lines;
	wire [7:0] data_in, data_out;
	logic [7:0] d, s;
	int n, err_count, n_checks;
	// Short second and recovery keep the run brief
	cal_clock_core #(.SEC_CYCLES(20), .REC_CYCLES(10)) i_cal_clock_core (.ref_clk, .arst_n,
		.osc_run, .supply_fail, .chip_sel_n, .out_en_n, .wr_en_n, .address_lines, .data_in,
		.data_out, .data_oe_n, .wake_input_n, .irq_n, .rst_n, .power_on_request_n);
	host_bus_model host (.ref_clk, .chip_sel_n, .out_en_n, .wr_en_n, .address_lines,
		.data_in, .data_out);
	// 100 MHz clock
	always #5 ref_clk = ~ref_clk;
	task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task give_verdict;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Bounded wait ran out
	task to_chk(input int lim);
		if (n >= lim) begin
			err_count++;
			$display("Error wait expected done seen timeout");
			give_verdict;
		end
	endtask
	// Reset out held for the recovery count
	task t_recovery;
		for (n = 0; n < 40 && rst_n !== 1'b1; n++) @(negedge ref_clk);
		to_chk(40);
		chk("recovery length", 8'h01, n >= 8 && n <= 12);
		$display("recovery done");
	endtask
	task t_reset_vals;
		host.rd(5'h04, d);
		chk("date", 8'h01, d);
		host.rd(5'h05, d);
		chk("month", 8'h01, d);
		$display("reset values done");
	endtask
	// Leap-year end of February, set while frozen
	task t_leap;
		host.wr(5'h0E, 8'h00);
		host.wr(5'h06, 8'h04);
		host.wr(5'h05, 8'h02);
		host.wr(5'h04, 8'h1D);
		host.wr(5'h02, 8'h17);
		host.wr(5'h01, 8'h3B);
		host.wr(5'h00, 8'h3B);
		host.rd(5'h01, d);
		chk("minutes", 8'h3B, d);
		host.rd(5'h07, d);
		chk("reserved", 8'h00, d);
		host.wr(5'h0E, 8'h80);
		repeat (25) @(negedge ref_clk);
		host.rd(5'h04, d);
		chk("date", 8'h01, d);
		host.rd(5'h05, d);
		chk("month", 8'h03, d);
		$display("leap done");
	endtask
	// Frozen visible set, then updates resume
	task t_freeze;
		host.wr(5'h0E, 8'h00);
		host.rd(5'h00, s);
		repeat (45) @(negedge ref_clk);
		host.rd(5'h00, d);
		chk("frozen seconds", s, d);
		host.wr(5'h0E, 8'h80);
		repeat (45) @(negedge ref_clk);
		host.rd(5'h00, d);
		chk("seconds kept running", 8'h01, d >= s + 8'h04);
		$display("freeze done");
	endtask
	// Oscillator stopped: time holds, then runs again
	task t_osc;
		osc_run = 1'b0;
		host.rd(5'h00, s);
		repeat (45) @(negedge ref_clk);
		host.rd(5'h00, d);
		chk("stopped seconds", s, d);
		osc_run = 1'b1;
		repeat (45) @(negedge ref_clk);
		host.rd(5'h00, d);
		chk("resumed seconds", 8'h01, d > s);
		$display("oscillator done");
	endtask
	// Wake edge raises interrupt and power request
	task t_wake;
		chk("irq idle", 8'h01, irq_n);
		host.wr(5'h0E, 8'hA4);
		wake_input_n = 1'b0;
		for (n = 0; n < 60 && (irq_n !== 1'b0 || power_on_request_n !== 1'b0); n++)
			@(negedge ref_clk);
		to_chk(60);
		wake_input_n = 1'b1;
		host.wr(5'h0D, 8'h84);
		repeat (4) @(negedge ref_clk);
		chk("power request", 8'h01, power_on_request_n);
		chk("irq cleared", 8'h01, irq_n);
		$display("wake done");
	endtask
	// Supply fail blocks the port and holds reset
	task t_fail;
		supply_fail = 1'b1;
		fork
			host.rd(5'h00, d);
			begin
				repeat (2) @(negedge ref_clk);
				chk("data enable", 8'h01, data_oe_n);
			end
		join
		chk("reset out", 8'h00, rst_n);
		supply_fail = 1'b0;
		t_recovery;
		$display("fail done");
	endtask
	// Alarm match raises interrupt; watchdog expiry pulses reset out
	task t_events;
		host.rd(5'h00, s);
		host.wr(5'h08, s + 8'h03);
		host.wr(5'h0D, 8'h07);
		host.wr(5'h0E, 8'h81);
		chk("irq before alarm", 8'h01, irq_n);
		for (n = 0; n < 100 && irq_n !== 1'b0; n++) @(negedge ref_clk);
		to_chk(100);
		host.rd(5'h00, d);
		chk("alarm second", s + 8'h03, d);
		host.wr(5'h0E, 8'h88);
		host.wr(5'h0C, 8'h02);
		for (n = 0; n < 60 && rst_n !== 1'b0; n++) @(negedge ref_clk);
		to_chk(60);
		t_recovery;
		host.wr(5'h0C, 8'h00);
		host.wr(5'h0E, 8'h80);
		$display("events done");
	endtask
	initial begin
		ref_clk = 1'b0;
		arst_n = 1'b0;
		osc_run = 1'b1;
		supply_fail = 1'b0;
		wake_input_n = 1'b1;
		repeat (5) @(negedge ref_clk);
		arst_n = 1'b1;
		t_recovery;
		t_reset_vals;
		t_leap;
		t_freeze;
		t_osc;
		t_wake;
		t_fail;
		t_events;
		give_verdict;
	end
endmodule
